// [rtl/dual_timer_pkg.sv]
// register map, field positions and mode codes for the dual timer block
package dual_timer_pkg;
    localparam logic [11:0] OFS_MODE_CFG = 12'h000;
    localparam logic [11:0] OFS_RUN_CTRL = 12'h004;
    localparam logic [11:0] OFS_UPPER_ZERO = 12'h008;
    localparam logic [11:0] OFS_LOWER_ZERO = 12'h00C;
    localparam logic [11:0] OFS_UPPER_ONE = 12'h010;
    localparam logic [11:0] OFS_LOWER_ONE = 12'h014;
    localparam logic [7:0] MODE_CFG_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int GATE_ONE_BIT = 7;
    localparam int SEL_ONE_BIT = 6;
    localparam int MODE_ONE_HI = 5;
    localparam int MODE_ONE_LO = 4;
    localparam int GATE_ZERO_BIT = 3;
    localparam int SEL_ZERO_BIT = 2;
    localparam int MODE_ZERO_HI = 1;
    localparam int MODE_ZERO_LO = 0;
    localparam int RUN_ZERO_BIT = 0;
    localparam int RUN_ONE_BIT = 1;
    localparam logic [4:0] PRESCALE_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_CASCADED = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_FOURTH = 2'b11
    } timer_mode_t;
endpackage : dual_timer_pkg

// [rtl/dual_timer.sv]
// two 16-bit timer/counters with mode configuration, reached over APB
// Overview of operation
// - timer one gated: advances only while its gate pin high and run set
// - timer zero gated: advances only while its gate pin high and run set, except the mode 11 upper byte
// - timer one select bit set counts event pin falls, else core clock
// - timer zero select bit set counts event pin falls, else core clock
// - mode field of timer one in bits 5:4, timer zero in bits 1:0
// - timer one mode 00: upper byte counts through 5-bit lower prescaler
// - timer one mode 01: both bytes form one 16-bit counter
// - timer one mode 10: lower byte counts, reloads from upper on overflow
// - timer one mode 11: timer one stops
// - timer zero mode 00: upper byte counts through 5-bit lower prescaler
// - timer zero mode 01: both bytes form one 16-bit counter
// - timer zero mode 10: lower byte counts, reloads from upper on overflow
// - timer zero mode 11: lower byte uses timer zero's own controls
// - timer zero mode 11: upper byte counts clock under timer one's run
// - timer operation increments once per core clock
// - counter operation increments on high then low pin samples
// - run bits turn each timer on and off, held in run register
`timescale 1ns/10ps
module dual_timer
    import dual_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic event_pin_zero,
    input wire logic event_pin_one
);
    logic [7:0] timer_mode_config_ff;
    logic run_ctrl_zero_ff;
    logic run_ctrl_one_ff;
    logic [7:0] upper_byte_zero_ff;
    logic [7:0] lower_byte_zero_ff;
    logic [7:0] upper_byte_one_ff;
    logic [7:0] lower_byte_one_ff;
    logic event_zero_ff;
    logic event_one_ff;
    logic [31:0] prdata_ff;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] nxt_prdata;
    timer_mode_t mode_zero;
    timer_mode_t mode_one;
    logic enable_zero;
    logic enable_one;
    logic tick_zero;
    logic tick_one;
    logic tick_upper_zero;
    logic [7:0] nxt_upper_zero;
    logic [7:0] nxt_lower_zero;
    logic [7:0] nxt_upper_one;
    logic [7:0] nxt_lower_one;

    // single-cycle access phase; unmapped addresses answer with pslverr
    assign pready = 1'b1;
    always_comb begin
        unique case (paddr)
            OFS_MODE_CFG, OFS_RUN_CTRL, OFS_UPPER_ZERO, OFS_LOWER_ZERO, OFS_UPPER_ONE, OFS_LOWER_ONE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok & pstrb[0];
    assign rd_en = psel & ~penable & ~pwrite;
    assign prdata = prdata_ff;

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_MODE_CFG: nxt_prdata[7:0] = timer_mode_config_ff;
            OFS_RUN_CTRL: nxt_prdata[1:0] = {run_ctrl_one_ff, run_ctrl_zero_ff};
            OFS_UPPER_ZERO: nxt_prdata[7:0] = upper_byte_zero_ff;
            OFS_LOWER_ZERO: nxt_prdata[7:0] = lower_byte_zero_ff;
            OFS_UPPER_ONE: nxt_prdata[7:0] = upper_byte_one_ff;
            OFS_LOWER_ONE: nxt_prdata[7:0] = lower_byte_one_ff;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // read data captured in setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_config_ff <= MODE_CFG_RESET;
        end else if (wr_en && paddr == OFS_MODE_CFG) begin
            timer_mode_config_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ctrl_zero_ff <= 1'b0;
            run_ctrl_one_ff <= 1'b0;
        end else if (wr_en && paddr == OFS_RUN_CTRL) begin
            run_ctrl_zero_ff <= pwdata[RUN_ZERO_BIT];
            run_ctrl_one_ff <= pwdata[RUN_ONE_BIT];
        end
    end

    // previous pin samples for falling-edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_zero_ff <= 1'b0;
            event_one_ff <= 1'b0;
        end else begin
            event_zero_ff <= event_pin_zero;
            event_one_ff <= event_pin_one;
        end
    end

    assign mode_zero = timer_mode_t'(timer_mode_config_ff[MODE_ZERO_HI:MODE_ZERO_LO]);
    assign mode_one = timer_mode_t'(timer_mode_config_ff[MODE_ONE_HI:MODE_ONE_LO]);

    assign enable_zero = run_ctrl_zero_ff & (~timer_mode_config_ff[GATE_ZERO_BIT] | gate_pin_zero);
    assign enable_one = run_ctrl_one_ff & (~timer_mode_config_ff[GATE_ONE_BIT] | gate_pin_one);

    // timer: every clock; counter: high sample then low sample
    assign tick_zero = enable_zero
        & (timer_mode_config_ff[SEL_ZERO_BIT] ? (event_zero_ff & ~event_pin_zero) : 1'b1);
    assign tick_one = enable_one
        & (timer_mode_config_ff[SEL_ONE_BIT] ? (event_one_ff & ~event_pin_one) : 1'b1);

    // in the fourth mode of timer zero the upper byte borrows timer one's run bit
    assign tick_upper_zero = run_ctrl_one_ff;

    always_comb begin
        nxt_upper_zero = upper_byte_zero_ff;
        nxt_lower_zero = lower_byte_zero_ff;
        unique case (mode_zero)
            MODE_PRESCALED: begin
                if (tick_zero) begin
                    nxt_lower_zero = {3'b000, lower_byte_zero_ff[4:0] + 5'h01};
                    if (lower_byte_zero_ff[4:0] == PRESCALE_MAX) begin
                        nxt_upper_zero = upper_byte_zero_ff + 8'h01;
                    end
                end
            end
            MODE_CASCADED: begin
                if (tick_zero) begin
                    {nxt_upper_zero, nxt_lower_zero} = {upper_byte_zero_ff, lower_byte_zero_ff} + 16'h0001;
                end
            end
            MODE_RELOAD: begin
                if (tick_zero) begin
                    nxt_lower_zero = (lower_byte_zero_ff == BYTE_MAX) ? upper_byte_zero_ff
                                                                       : lower_byte_zero_ff + 8'h01;
                end
            end
            MODE_FOURTH: begin
                if (tick_zero) begin
                    nxt_lower_zero = lower_byte_zero_ff + 8'h01;
                end
                if (tick_upper_zero) begin
                    nxt_upper_zero = upper_byte_zero_ff + 8'h01;
                end
            end
        endcase
    end

    always_comb begin
        nxt_upper_one = upper_byte_one_ff;
        nxt_lower_one = lower_byte_one_ff;
        unique case (mode_one)
            MODE_PRESCALED: begin
                if (tick_one) begin
                    nxt_lower_one = {3'b000, lower_byte_one_ff[4:0] + 5'h01};
                    if (lower_byte_one_ff[4:0] == PRESCALE_MAX) begin
                        nxt_upper_one = upper_byte_one_ff + 8'h01;
                    end
                end
            end
            MODE_CASCADED: begin
                if (tick_one) begin
                    {nxt_upper_one, nxt_lower_one} = {upper_byte_one_ff, lower_byte_one_ff} + 16'h0001;
                end
            end
            MODE_RELOAD: begin
                if (tick_one) begin
                    nxt_lower_one = (lower_byte_one_ff == BYTE_MAX) ? upper_byte_one_ff
                                                                     : lower_byte_one_ff + 8'h01;
                end
            end
            MODE_FOURTH: begin
                nxt_lower_one = lower_byte_one_ff;
            end
        endcase
    end

    // software writes take priority over a count in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_byte_zero_ff <= BYTE_RESET;
            lower_byte_zero_ff <= BYTE_RESET;
        end else begin
            upper_byte_zero_ff <= (wr_en && paddr == OFS_UPPER_ZERO) ? pwdata[7:0] : nxt_upper_zero;
            lower_byte_zero_ff <= (wr_en && paddr == OFS_LOWER_ZERO) ? pwdata[7:0] : nxt_lower_zero;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_byte_one_ff <= BYTE_RESET;
            lower_byte_one_ff <= BYTE_RESET;
        end else begin
            upper_byte_one_ff <= (wr_en && paddr == OFS_UPPER_ONE) ? pwdata[7:0] : nxt_upper_one;
            lower_byte_one_ff <= (wr_en && paddr == OFS_LOWER_ONE) ? pwdata[7:0] : nxt_lower_one;
        end
    end

    logic wr_upper_zero;
    logic wr_lower_zero;
    logic wr_upper_one;
    logic wr_lower_one;
    assign wr_upper_zero = wr_en && paddr == OFS_UPPER_ZERO;
    assign wr_lower_zero = wr_en && paddr == OFS_LOWER_ZERO;
    assign wr_upper_one = wr_en && paddr == OFS_UPPER_ONE;
    assign wr_lower_one = wr_en && paddr == OFS_LOWER_ONE;

    gate_zero_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_ctrl_zero_ff && mode_zero != MODE_FOURTH && !wr_lower_zero) |=> $stable(lower_byte_zero_ff))
        else $error("timer zero lower byte moved while its run bit clear");
    gate_one_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_mode_config_ff[GATE_ONE_BIT] && !gate_pin_one && mode_one == MODE_CASCADED && !wr_lower_one
         && !wr_upper_one) |=> $stable({upper_byte_one_ff, lower_byte_one_ff}))
        else $error("gated timer one moved with gate pin low");
    timer_one_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_one_ff && !timer_mode_config_ff[GATE_ONE_BIT] && !timer_mode_config_ff[SEL_ONE_BIT]
         && mode_one == MODE_CASCADED && !wr_lower_one && !wr_upper_one)
        |=> {upper_byte_one_ff, lower_byte_one_ff} == $past({upper_byte_one_ff, lower_byte_one_ff}) + 16'h0001)
        else $error("timer one did not advance by one in timer operation");
    counter_zero_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_mode_config_ff[SEL_ZERO_BIT] && !wr_lower_zero
         && !(event_zero_ff && !event_pin_zero)) |=> $stable(lower_byte_zero_ff))
        else $error("counter zero moved without a falling pin");
    reload_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_one && mode_one == MODE_RELOAD && lower_byte_one_ff == BYTE_MAX && !wr_lower_one && !wr_upper_one)
        |=> lower_byte_one_ff == upper_byte_one_ff)
        else $error("timer one reload missed");
    stop_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_one == MODE_FOURTH && !wr_lower_one && !wr_upper_one)
        |=> $stable({upper_byte_one_ff, lower_byte_one_ff}))
        else $error("timer one moved in stopped mode");
    prescale_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_zero && mode_zero == MODE_PRESCALED && lower_byte_zero_ff[4:0] == PRESCALE_MAX && !wr_upper_zero
         && !wr_lower_zero)
        |=> upper_byte_zero_ff == $past(upper_byte_zero_ff) + 8'h01 && lower_byte_zero_ff == BYTE_RESET)
        else $error("timer zero prescaler carry wrong");
    split_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_zero == MODE_FOURTH && run_ctrl_one_ff && !wr_upper_zero)
        |=> upper_byte_zero_ff == $past(upper_byte_zero_ff) + 8'h01)
        else $error("split upper byte did not follow timer one run bit");
    split_upper_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_zero == MODE_FOURTH && !run_ctrl_one_ff && !wr_upper_zero) |=> $stable(upper_byte_zero_ff))
        else $error("split upper byte moved while timer one run bit clear");

    // gate pins and counter select
    gate_zero_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_mode_config_ff[GATE_ZERO_BIT] && !gate_pin_zero && mode_zero == MODE_CASCADED && !wr_lower_zero
         && !wr_upper_zero) |=> $stable({upper_byte_zero_ff, lower_byte_zero_ff}))
        else $error("gated timer zero moved with gate pin low");
    gate_one_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_one_ff && timer_mode_config_ff[GATE_ONE_BIT] && gate_pin_one && !timer_mode_config_ff[SEL_ONE_BIT]
         && mode_one == MODE_CASCADED && !wr_lower_one && !wr_upper_one)
        |=> {upper_byte_one_ff, lower_byte_one_ff} == $past({upper_byte_one_ff, lower_byte_one_ff}) + 16'h0001)
        else $error("gated timer one did not advance with gate pin high");
    count_zero_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_zero_ff && !timer_mode_config_ff[GATE_ZERO_BIT] && timer_mode_config_ff[SEL_ZERO_BIT]
         && mode_zero == MODE_CASCADED && event_zero_ff && !event_pin_zero && !wr_lower_zero && !wr_upper_zero)
        |=> {upper_byte_zero_ff, lower_byte_zero_ff} == $past({upper_byte_zero_ff, lower_byte_zero_ff}) + 16'h0001)
        else $error("counter zero missed a falling pin");
    count_one_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_mode_config_ff[SEL_ONE_BIT] && mode_one == MODE_CASCADED && !(event_one_ff && !event_pin_one)
         && !wr_lower_one && !wr_upper_one) |=> $stable({upper_byte_one_ff, lower_byte_one_ff}))
        else $error("counter one moved without a falling pin");

    // timer operation per mode
    cascade_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_zero_ff && !timer_mode_config_ff[GATE_ZERO_BIT] && !timer_mode_config_ff[SEL_ZERO_BIT]
         && mode_zero == MODE_CASCADED && !wr_lower_zero && !wr_upper_zero)
        |=> {upper_byte_zero_ff, lower_byte_zero_ff} == $past({upper_byte_zero_ff, lower_byte_zero_ff}) + 16'h0001)
        else $error("timer zero cascade did not advance by one");
    prescale_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_one_ff && !timer_mode_config_ff[GATE_ONE_BIT] && !timer_mode_config_ff[SEL_ONE_BIT]
         && mode_one == MODE_PRESCALED && lower_byte_one_ff[4:0] != PRESCALE_MAX && !wr_lower_one && !wr_upper_one)
        |=> $stable(upper_byte_one_ff) && lower_byte_one_ff[4:0] == $past(lower_byte_one_ff[4:0]) + 5'h01)
        else $error("timer one prescaler step wrong");
    reload_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_zero_ff && !timer_mode_config_ff[GATE_ZERO_BIT] && !timer_mode_config_ff[SEL_ZERO_BIT]
         && mode_zero == MODE_RELOAD && lower_byte_zero_ff == BYTE_MAX && !wr_lower_zero && !wr_upper_zero)
        |=> lower_byte_zero_ff == upper_byte_zero_ff)
        else $error("timer zero reload missed");
    split_lower_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_ctrl_zero_ff && !timer_mode_config_ff[GATE_ZERO_BIT] && !timer_mode_config_ff[SEL_ZERO_BIT]
         && mode_zero == MODE_FOURTH && !wr_lower_zero)
        |=> lower_byte_zero_ff == $past(lower_byte_zero_ff) + 8'h01)
        else $error("split lower byte did not follow timer zero controls");

    // software access to run bits, bytes and the mode register
    run_bit_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pstrb[0] && paddr == OFS_RUN_CTRL)
        |=> run_ctrl_zero_ff == $past(pwdata[RUN_ZERO_BIT]) && run_ctrl_one_ff == $past(pwdata[RUN_ONE_BIT]))
        else $error("run bits did not take the written value");
    hold_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_ctrl_one_ff && !wr_lower_one && !wr_upper_one) |=> $stable({upper_byte_one_ff, lower_byte_one_ff}))
        else $error("timer one bytes moved while its run bit clear");
    write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pstrb[0] && paddr == OFS_LOWER_ZERO)
        |=> lower_byte_zero_ff == $past(pwdata[7:0]))
        else $error("lower byte of timer zero lost a software write");
    read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_MODE_CFG)
        |=> prdata == {24'h00_0000, $past(timer_mode_config_ff)})
        else $error("mode register read data wrong");

    cover_reload_c: cover property (@(posedge pclk) disable iff (!presetn)
        tick_zero && mode_zero == MODE_RELOAD && lower_byte_zero_ff == BYTE_MAX);
    cover_count_c: cover property (@(posedge pclk) disable iff (!presetn)
        tick_one && timer_mode_config_ff[SEL_ONE_BIT]);
    cover_split_c: cover property (@(posedge pclk) disable iff (!presetn)
        mode_zero == MODE_FOURTH && tick_zero && run_ctrl_one_ff);
    cover_prescale_c: cover property (@(posedge pclk) disable iff (!presetn)
        tick_zero && mode_zero == MODE_PRESCALED && lower_byte_zero_ff[4:0] == PRESCALE_MAX);
    cover_gate_c: cover property (@(posedge pclk) disable iff (!presetn)
        timer_mode_config_ff[GATE_ONE_BIT] && gate_pin_one && tick_one);
endmodule : dual_timer

// [verification/timer_pin_model.sv]
// pin-side model driving the gate and count inputs of the dual timer
`timescale 1ns/10ps
module timer_pin_model (
    input wire logic pclk,
    output logic gate_pin_zero,
    output logic gate_pin_one,
    output logic event_pin_zero,
    output logic event_pin_one
);
    initial begin
        gate_pin_zero = 1'b0;
        gate_pin_one = 1'b0;
        event_pin_zero = 1'b0;
        event_pin_one = 1'b0;
    end
    task automatic set_gates(input logic g0, input logic g1);
        @(posedge pclk);
        gate_pin_zero <= g0;
        gate_pin_one <= g1;
    endtask : set_gates
    // each level is held two cycles, above the one-cycle minimum
    task automatic pulse(input int n0, input int n1);
        for (int i = 0; i < ((n0 > n1) ? n0 : n1); i++) begin
            event_pin_zero <= (i < n0);
            event_pin_one <= (i < n1);
            repeat (2) @(posedge pclk);
            event_pin_zero <= 1'b0;
            event_pin_one <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : pulse
endmodule : timer_pin_model

// [verification/dual_timer_tb.sv]
// self-checking bench for the dual timer over APB
`timescale 1ns/10ps
module dual_timer_tb;
    import dual_timer_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, seen_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic gate_pin_zero, gate_pin_one, event_pin_zero, event_pin_one;
    int bad_count = 0;
    int total_checks = 0;
    dual_timer u_dual_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one),
        .event_pin_zero(event_pin_zero), .event_pin_one(event_pin_one));
    timer_pin_model u_timer_pin_model (.pclk(pclk), .gate_pin_zero(gate_pin_zero),
        .gate_pin_one(gate_pin_one), .event_pin_zero(event_pin_zero), .event_pin_one(event_pin_one));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        seen_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic set_bytes(input logic [7:0] u0, l0, u1, l1);
        apb(1'b1, OFS_UPPER_ZERO, {24'h0, u0});
        apb(1'b1, OFS_LOWER_ZERO, {24'h0, l0});
        apb(1'b1, OFS_UPPER_ONE, {24'h0, u1});
        apb(1'b1, OFS_LOWER_ONE, {24'h0, l1});
    endtask : set_bytes
    task automatic chk4(input logic [7:0] u0, l0, u1, l1);
        apb(1'b0, OFS_UPPER_ZERO, 32'h0);
        chk("upper_byte_zero", rdat, {24'h0, u0});
        apb(1'b0, OFS_LOWER_ZERO, 32'h0);
        chk("lower_byte_zero", rdat, {24'h0, l0});
        apb(1'b0, OFS_UPPER_ONE, 32'h0);
        chk("upper_byte_one", rdat, {24'h0, u1});
        apb(1'b0, OFS_LOWER_ONE, 32'h0);
        chk("lower_byte_one", rdat, {24'h0, l1});
    endtask : chk4
    // run bits stay set for k+3 counting edges because of the write spacing
    task automatic run_for(input logic [1:0] run, input int k);
        apb(1'b1, OFS_RUN_CTRL, {30'h0, run});
        repeat (k) @(posedge pclk);
        apb(1'b1, OFS_RUN_CTRL, 32'h0);
    endtask : run_for
    initial begin
        #(4000 * 50);
        bad_count++;
        give_verdict();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_MODE_CFG, 32'h0);
        chk("mode_cfg reset", rdat, {24'h0, MODE_CFG_RESET});
        chk("pready", {31'h0, pready}, 32'h1);
        chk4(8'h00, 8'h00, 8'h00, 8'h00);
        apb(1'b1, OFS_MODE_CFG, 32'h0000_00A5);
        apb(1'b1, 12'h020, 32'h0000_00FF);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped data", rdat, 32'h0);
        chk("unmapped error", {31'h0, seen_err}, 32'h1);
        pstrb <= 4'h0;
        apb(1'b1, OFS_MODE_CFG, 32'h0000_00FF);
        pstrb <= 4'hF;
        apb(1'b0, OFS_MODE_CFG, 32'h0);
        chk("mode_cfg", rdat, 32'h0000_00A5);
        chk("mapped error", {31'h0, seen_err}, 32'h0);
        $display("test registers done");
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0001);
        set_bytes(8'h00, 8'hFE, 8'h05, 8'h1E);
        run_for(2'b11, 32);
        chk4(8'h01, 8'h21, 8'h07, 8'h01);
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0010);
        set_bytes(8'h03, 8'h1D, 8'h00, 8'hFC);
        run_for(2'b11, 2);
        chk4(8'h04, 8'h02, 8'h01, 8'h01);
        $display("test prescaled and cascaded done");
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0032);
        set_bytes(8'hF0, 8'hFC, 8'h22, 8'h11);
        run_for(2'b11, 7);
        chk4(8'hF0, 8'hF6, 8'h22, 8'h11);
        $display("test reload and stop done");
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0023);
        set_bytes(8'h10, 8'h20, 8'h40, 8'hFD);
        run_for(2'b10, 2);
        chk4(8'h15, 8'h20, 8'h40, 8'h42);
        run_for(2'b01, 2);
        chk4(8'h15, 8'h25, 8'h40, 8'h42);
        $display("test split mode done");
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0099);
        set_bytes(8'h00, 8'h00, 8'h00, 8'h00);
        u_timer_pin_model.set_gates(1'b1, 1'b0);
        run_for(2'b11, 5);
        chk4(8'h00, 8'h08, 8'h00, 8'h00);
        u_timer_pin_model.set_gates(1'b0, 1'b1);
        run_for(2'b11, 5);
        chk4(8'h00, 8'h08, 8'h00, 8'h08);
        $display("test gating done");
        apb(1'b1, OFS_MODE_CFG, 32'h0000_0055);
        set_bytes(8'h00, 8'h00, 8'h00, 8'h00);
        apb(1'b1, OFS_RUN_CTRL, 32'h0000_0003);
        u_timer_pin_model.pulse(3, 6);
        apb(1'b1, OFS_RUN_CTRL, 32'h0);
        chk4(8'h00, 8'h03, 8'h00, 8'h06);
        $display("test event counting done");
        give_verdict();
    end
endmodule : dual_timer_tb
